/* File: swrb_pkg.sv */
// Constants shared by the serial word receive buffer.
package swrb_pkg;
   localparam int WORD_BITS = 32;
   localparam int BYTE_BITS = 8;
   localparam int BYTES_PER_WORD = 4;
   localparam int GAP_TICKS = 16;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
   localparam logic [ADDR_W-1:0] WORD_OFFSET = 4'h8;
   localparam int CTRL_PARITY_BIT = 0;
   localparam int CTRL_BYPASS_A_BIT = 1;
   localparam int CTRL_BYPASS_B_BIT = 2;
   localparam int STATUS_READY_BIT = 0;
   localparam int STATUS_ERROR_BIT = 1;
   localparam int STATUS_ARMED_BIT = 2;
   localparam int STATUS_PTR_LSB = 4;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : swrb_pkg

/* File: swrb_top.sv */
// Serial word receive buffer with strobed byte port and AXI4-Lite control.
// Functional notes
// RULE1: At a word gap the shifted word moves to the buffer and is checked.
// RULE2: Parity selected: odd parity checked, a failure forces stored bit 32 to one.
// RULE3: Parity not selected: bit 32 is stored exactly as received.
// RULE4: At a gap, error goes high if the bit count since last gap is not 32.
// RULE5: Error clears on the next valid word into the buffer, or on reset.
// RULE6: Word-ready rises when a word enters the buffer.
// RULE7: Host reads four bytes with low strobes; the first clears word-ready.
// RULE8: Byte pointer advances on each strobe until all four bytes are read.
// RULE9: Bits 1-8 come first, then 9-16, 17-24, 25-32; lowest bit on line 0.
// RULE10: Each completed word overwrites the buffer, read or not.
// RULE11: A new word returns the byte pointer to the first byte.
// RULE12: Low reset initialises all internal logic.
// RULE13: After reset, bits are ignored until the first word gap.
// RULE14: Bypass inputs override the line receiver per the fixed pattern table.
// RULE15: Controller pulses reset right after entering test mode; the testbench pulses it right before, since reset clears the bypass bits.
// RULE16: Controller holds both bypass inputs high for 17 gap clocks after reset.
// RULE17: Controller leaves test mode with bypass inputs low, then resets.
// RULE18: A gap is 16 idle gap-clock cycles, 16 to 17 with asynchronous timing; the code fires on the 16th tick, after 15 to 16 periods.
// RULE19: While the read strobe is low the selected byte is driven out.
// RULE20: Data lines float while the read strobe is high.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
module swrb_top #(
   parameter int GAP_COUNT = swrb_pkg::GAP_TICKS
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic line_input_pos,
   input wire logic line_input_neg,
   input wire logic word_gap_timebase,
   input wire logic readStrobeN,
   output logic [swrb_pkg::BYTE_BITS-1:0] parallelByteBus,
   output logic parallelByteBusEnN,
   output logic wordReady,
   output logic wordError,
   input wire logic [swrb_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [swrb_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import swrb_pkg::*;

   initial begin
      if (GAP_COUNT < 2 || GAP_COUNT > 255) begin
         $error("GAP_COUNT out of range");
      end
   end

   // Pin inputs: two flops each, a third stage only where an edge is needed.
   logic [1:0] posSync;
   logic [1:0] negSync;
   logic [2:0] tbSync;
   logic [2:0] rdSync;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         posSync <= 2'h0;
         negSync <= 2'h0;
         tbSync <= 3'h0;
         rdSync <= 3'h7;
      end else begin
         posSync <= {posSync[0], line_input_pos};
         negSync <= {negSync[0], line_input_neg};
         tbSync <= {tbSync[1:0], word_gap_timebase};
         rdSync <= {rdSync[1:0], readStrobeN};
      end
   end

   logic [2:0] ctrl;
   wire parEn = ctrl[CTRL_PARITY_BIT];
   wire bypA = ctrl[CTRL_BYPASS_A_BIT];
   wire bypB = ctrl[CTRL_BYPASS_B_BIT];
   // Bypass pattern 1,1 yields null, so test mode can force a clean gap.
   wire bypassOn = bypA | bypB;
   wire receiver_out_a = bypassOn ? (bypA & ~bypB) : posSync[1]; // [RULE14]
   wire receiver_out_b = bypassOn ? (bypB & ~bypA) : negSync[1]; // [RULE14]
   wire active = receiver_out_a | receiver_out_b;
   wire gapTick = tbSync[1] & ~tbSync[2];
   wire readFall = ~rdSync[1] & rdSync[2];
   wire readRise = rdSync[1] & ~rdSync[2];

   logic prevActive;
   logic [7:0] gapCnt;
   logic gapFired;
   logic armed;
   logic [WORD_BITS-1:0] shiftReg;
   logic [5:0] bitCount;
   logic [WORD_BITS-1:0] rxBuffer;
   logic [2:0] bytePtr;

   // The first timebase period is partial, giving 15 to 16 periods of idle.
   wire gapNow = !active && gapTick && !gapFired && gapCnt == 8'(GAP_COUNT - 1); // [RULE18]
   wire bitEdge = active && !prevActive && armed; // [RULE13]
   wire parityFail = ~^shiftReg; // [RULE2]
   wire countBad = bitCount != 6'(WORD_BITS); // [RULE4]
   wire newError = countBad | (parEn & parityFail); // [RULE4]
   wire [WORD_BITS-1:0] storedWord = {parEn ? (shiftReg[WORD_BITS-1] | parityFail) : shiftReg[WORD_BITS-1],
                                      shiftReg[WORD_BITS-2:0]}; // [RULE2] [RULE3]
   wire transfer = gapNow && armed; // [RULE1]
   wire [1:0] byteSel = bytePtr[2] ? 2'h3 : bytePtr[1:0];
   wire [BYTE_BITS-1:0] selByte = rxBuffer[byteSel*BYTE_BITS +: BYTE_BITS]; // [RULE9]

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prevActive <= 1'b0;
         gapCnt <= 8'h00;
         gapFired <= 1'b0;
      end else begin
         prevActive <= active;
         if (active) begin
            gapCnt <= 8'h00;
            gapFired <= 1'b0;
         end else if (gapNow) begin
            gapCnt <= 8'h00;
            gapFired <= 1'b1;
         end else if (gapTick && !gapFired) begin
            gapCnt <= gapCnt + 8'h01;
         end
      end
   end

   // Bit one is shifted in first and ends up at position zero.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         armed <= 1'b0; // [RULE12]
         shiftReg <= ZERO_WORD;
         bitCount <= 6'h00;
      end else begin
         if (gapNow) begin
            armed <= 1'b1; // [RULE13]
            bitCount <= 6'h00;
         end else if (bitEdge) begin
            shiftReg <= {receiver_out_a, shiftReg[WORD_BITS-1:1]};
            if (bitCount != 6'h3F) begin
               bitCount <= bitCount + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rxBuffer <= ZERO_WORD;
         wordError <= 1'b0; // [RULE5]
      end else begin
         if (transfer) begin
            rxBuffer <= storedWord; // [RULE10]
            wordError <= newError; // [RULE5]
         end
      end
   end

   // A new word in the same cycle as the first strobe keeps ready set.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wordReady <= 1'b0;
      end else begin
         if (transfer) begin
            wordReady <= 1'b1; // [RULE6]
         end else if (readFall && bytePtr == 3'h0) begin
            wordReady <= 1'b0; // [RULE7]
         end
      end
   end

   // The pointer moves at the end of each strobe so the byte stays put while it is low.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bytePtr <= 3'h0;
      end else begin
         if (transfer) begin
            bytePtr <= 3'h0; // [RULE11]
         end else if (readRise && bytePtr != 3'(BYTES_PER_WORD)) begin
            bytePtr <= bytePtr + 3'h1; // [RULE8]
         end
      end
   end

   // The bus shows zero while floating, so a missing tri-state buffer reads as a null byte.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         parallelByteBus <= 8'h00;
         parallelByteBusEnN <= 1'b1;
      end else begin
         parallelByteBusEnN <= rdSync[1]; // [RULE19] [RULE20]
         parallelByteBus <= rdSync[1] ? 8'h00 : selByte; // [RULE19]
      end
   end

   // AXI4-Lite slave: write address and data are taken together.
   wire wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   wire rdGo = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   wire wrCtrl = s_axi_awaddr == CTRL_OFFSET;
   wire [31:0] statusWord = {25'h000_0000, bytePtr, 1'b0, armed, wordError, wordReady};

   // Write and read answers share one decode, so the two can never disagree on the map.
   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      return a == CTRL_OFFSET || a == STATUS_OFFSET || a == WORD_OFFSET;
   endfunction : isMapped

   wire wrMapped = isMapped(s_axi_awaddr);
   wire rdOk = isMapped(s_axi_araddr);
   wire [31:0] rdMux = s_axi_araddr == CTRL_OFFSET ? {29'h0000_0000, ctrl} :
                       s_axi_araddr == STATUS_OFFSET ? statusWord :
                       s_axi_araddr == WORD_OFFSET ? rxBuffer : ZERO_WORD;

   // Ready pulses for one cycle only, which keeps a second take from following the first.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= wrGo;
         s_axi_wready <= wrGo;
      end
   end

   // The response stands until the master takes it; a new write is held off meanwhile.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wrGo) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only the lowest byte lane carries control bits; the upper lanes are ignored.
   // Reset clears the bypass bits, so test mode must be set up again after each reset.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl <= CTRL_RESET;
      end else if (wrGo && wrCtrl && s_axi_wstrb[0]) begin
         ctrl <= s_axi_wdata[2:0];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= rdGo;
      end
   end

   // Read data is captured at the take, so a word arriving later cannot tear the answer.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= ZERO_WORD;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         if (rdGo) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : swrb_top

/* File: swrb_monitor.sv */
// Port checker for the serial word receive buffer.
module swrb_monitor (
   input wire logic clock,
   input wire logic rstn,
   input wire logic readStrobeN,
   input wire logic [7:0] parallelByteBus,
   input wire logic parallelByteBusEnN,
   input wire logic wordReady,
   input wire logic wordError,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   a_bus_floats: assert property (parallelByteBusEnN |-> parallelByteBus == 8'h00)
      else $error("Byte bus not idle.");
   a_strobe_drives: assert property ($fell(readStrobeN) |-> ##[2:4] !parallelByteBusEnN)
      else $error("Byte not driven.");
   a_release_floats: assert property ($rose(readStrobeN) |-> ##[2:4] parallelByteBusEnN)
      else $error("Byte bus not released.");
   a_read_clears_ready: assert property ($fell(parallelByteBusEnN) |-> !wordReady)
      else $error("Ready not cleared.");
   a_error_on_load: assert property ($changed(wordError) |-> wordReady)
      else $error("Error moved without a word.");
   a_idle_after_reset: assert property ($rose(rstn) |-> !wordReady [*8])
      else $error("Word before first gap.");
   a_write_answer: assert property (s_axi_awready |-> s_axi_wready && s_axi_bvalid)
      else $error("Write answer split.");
   a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
      else $error("Read answer late.");
   a_resp_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("Write response held.");
   cover property ($rose(wordReady));
   cover property ($rose(wordError));
   cover property ($fell(parallelByteBusEnN));
endmodule : swrb_monitor

bind swrb_top swrb_monitor swrb_monitor_inst (.*);

/* File: swrb_host_model.sv */
// Host model that fetches bytes over the strobed byte port.
module swrb_host_model (
   input wire logic clock,
   output logic readStrobeN,
   input wire logic [7:0] parallelByteBus,
   input wire logic parallelByteBusEnN
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [7:0] busLine = parallelByteBusEnN ? 8'hzz : parallelByteBus;
   initial readStrobeN = 1'b1;
   // The strobe stays up six cycles so the device floats and advances first.
   task automatic readByte(output logic [7:0] b);
      readStrobeN <= 1'b0;
      do @(posedge clock); while (parallelByteBusEnN);
      b = busLine;
      readStrobeN <= 1'b1;
      repeat (6) @(posedge clock);
   endtask : readByte
endmodule : swrb_host_model

/* File: tb_serial_word_receive_buffer.sv */
// Testbench for the serial word receive buffer.
module tb_serial_word_receive_buffer;
   import swrb_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rstn = 0, line_input_pos = 0, line_input_neg = 0, word_gap_timebase = 0;
   logic readStrobeN, parallelByteBusEnN, wordReady, wordError, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] parallelByteBus, b;
   logic [31:0] w = 32'hA5C3_1E87;
   int failures = 0, compares = 0;
   swrb_top #(.GAP_COUNT(4)) swrb_top_inst (.*);
   swrb_host_model swrb_host_model_inst (.*);
   initial forever #5 clock = ~clock;
   initial forever #50 word_gap_timebase = ~word_gap_timebase;
   task automatic check(input string n, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s exp %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      if (failures == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge clock); while (!s_axi_awready);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      while (!s_axi_bvalid) @(posedge clock);
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask : axiWrite
   task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clock);
      d = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask : axiRead
   // Each bit is a short pulse on one line and a null, then the idle gap follows.
   task automatic sendWord(input logic [31:0] x, input int n);
      for (int i = 0; i < n; i++) begin
         line_input_pos <= x[i];
         line_input_neg <= !x[i];
         repeat (4) @(posedge clock);
         line_input_pos <= 1'b0;
         line_input_neg <= 1'b0;
         repeat (4) @(posedge clock);
      end
      repeat (150) begin
         @(posedge clock);
         if (wordReady) break;
      end
   endtask : sendWord
   // Test mode: each bit is a single bypass pattern followed by the null pattern.
   task automatic sendBypass(input logic [31:0] x);
      for (int i = 0; i < 32; i++) begin
         axiWrite(CTRL_OFFSET, x[i] ? 32'h0000_0002 : 32'h0000_0004);
         axiWrite(CTRL_OFFSET, 32'h0000_0006);
      end
      repeat (150) begin
         @(posedge clock);
         if (wordReady) break;
      end
   endtask : sendBypass
   task automatic wordIs(input logic [31:0] x);
      axiRead(WORD_OFFSET, v, r);
      check("word", v, x);
   endtask : wordIs
   initial begin
      #300000;
      failures++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      repeat (100) @(posedge clock);
      sendWord(w, 32);
      check("rdy", wordReady, 1'b1);
      check("err", wordError, 1'b0);
      wordIs(w);
      for (int i = 0; i < 5; i++) begin
         swrb_host_model_inst.readByte(b);
         check("byte", b, w[8 * (i > 3 ? 3 : i) +: 8]);
         if (i == 0) check("rdy", wordReady, 1'b0);
      end
      sendWord(32'h0000_1234, 31);
      check("err", wordError, 1'b1);
      swrb_host_model_inst.readByte(b);
      w = 32'h3C69_F00D;
      sendWord(w, 32);
      check("err", wordError, 1'b0);
      swrb_host_model_inst.readByte(b);
      sendWord(32'h0000_00E1, 32);
      swrb_host_model_inst.readByte(b);
      check("first", b, 8'hE1);
      wordIs(32'h0000_00E1);
      axiWrite(CTRL_OFFSET, 32'h0000_0001);
      sendWord(32'h0000_0003, 32);
      check("err", wordError, 1'b1);
      wordIs(32'h8000_0003);
      swrb_host_model_inst.readByte(b);
      sendWord(32'h0000_0007, 32);
      check("err", wordError, 1'b0);
      axiRead(4'hC, v, r);
      check("resp", r, RESP_SLVERR);
      check("data", v, ZERO_WORD);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      check("rdy", wordReady, 1'b0);
      rstn <= 1'b1;
      sendWord(32'h0000_00FF, 8);
      check("rdy", wordReady, 1'b0);
      sendWord(w, 32);
      wordIs(w);
      rstn <= 1'b0;
      @(posedge clock);
      rstn <= 1'b1;
      axiWrite(CTRL_OFFSET, 32'h0000_0006);
      repeat (200) @(posedge clock);
      sendBypass(32'h8C4E_0A35);
      check("rdy", wordReady, 1'b1);
      check("err", wordError, 1'b0);
      wordIs(32'h8C4E_0A35);
      axiWrite(CTRL_OFFSET, ZERO_WORD);
      rstn <= 1'b0;
      @(posedge clock);
      rstn <= 1'b1;
      check("rdy", wordReady, 1'b0);
      stop_test();
   end
endmodule : tb_serial_word_receive_buffer
